//--- duc_serial_pkg.sv
// constants, register map and types for the serial baseband input pair
// assumes one 100 MHz core clock and an AHB-Lite register port
package duc_serial_pkg;
  // structure of one even/odd block pair
  localparam int BLOCKS = 2;
  localparam int LANES = 4;
  localparam int SYNC_SRCS = 8;
  localparam int SR_W = 32;
  localparam int WORD_KEEP = 18;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 8;

  // sync event to first bit strobe: counter load is clkdiv plus this
  localparam logic [4:0] SYNC_LOAD_ADJ = 5'h01;
  localparam logic [6:0] FSINV_MIN = 7'h01;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CLKDIV = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FRAME = 8'h04;
  localparam logic [ADDR_W-1:0] REG_WORD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FSDEL = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_SYNC = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_LAST_I = 8'h1C;

  // mode register bits and the status strobe bit
  localparam int MODE_FOUR_PIN = 0;
  localparam int MODE_CDMA_EVEN = 1;
  localparam int MODE_CDMA_ODD = 2;
  localparam int STATUS_STROBE = 7;

  // reset values
  localparam logic [3:0] RST_CLKDIV = 4'h0;
  localparam logic [6:0] RST_FSINV = 7'h24;
  localparam logic [4:0] RST_BITS = 5'h11;
  localparam logic [1:0] RST_FSDEL = 2'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [2:0] RST_SSEL = 3'h0;

  // bus encodings
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    LANE_IDLE = 2'b00,
    LANE_WORD0 = 2'b01,
    LANE_WORD1 = 2'b11
  } lane_state_t;
endpackage

//--- lane_if.sv
// signals between the pair controller and one serial word lane
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface lane_if;
  import duc_serial_pkg::*;
  logic bit_stb;
  logic frame_start;
  logic [1:0] din;
  logic two_bit;
  logic two_words;
  logic [CNT_W-1:0] word_len;
  logic [WORD_KEEP-1:0] w0;
  logic [WORD_KEEP-1:0] w1;
  logic done;
  modport ctrl (output bit_stb, frame_start, din, two_bit, two_words,
                output word_len, input w0, w1, done);
  modport lane (input bit_stb, frame_start, din, two_bit, two_words,
                input word_len, output w0, w1, done);
endinterface

//--- serial_word_lane.sv
// one serial lane: shifts one or two bits per bit strobe into words
// assumes din already synchronised to core_clk by the pair controller
`timescale 1ns/1ps
module serial_word_lane import duc_serial_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // controller side
  lane_if.lane lp
);
  lane_state_t state_q, state_d;
  logic [SR_W-1:0] sr_q, sr_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [WORD_KEEP-1:0] w0_q, w0_d, w1_q, w1_d;
  logic done_q, done_d;
  logic [SR_W-1:0] base_sr, new_sr, aligned;
  logic [CNT_W-1:0] base_cnt, new_cnt;
  lane_state_t cur;

  always_comb begin
    state_d = state_q;
    sr_d = sr_q;
    cnt_d = cnt_q;
    w0_d = w0_q;
    w1_d = w1_q;
    done_d = 1'b0;
    cur = lp.frame_start ? LANE_WORD0 : state_q;
    base_sr = lp.frame_start ? '0 : sr_q;
    base_cnt = lp.frame_start ? '0 : cnt_q;
    // msb first: in two-bit mode pin a holds the higher bit
    new_sr = lp.two_bit ? {base_sr[SR_W-3:0], lp.din}
                        : {base_sr[SR_W-2:0], lp.din[0]};
    new_cnt = base_cnt + (lp.two_bit ? CNT_W'(2) : CNT_W'(1));
    // left align so only the upper bits of a long word survive
    aligned = new_sr << (CNT_W'(SR_W) - new_cnt);
    if (lp.bit_stb && cur != LANE_IDLE) begin
      sr_d = new_sr;
      cnt_d = new_cnt;
      state_d = cur;
      if (new_cnt >= lp.word_len) begin
        sr_d = '0;
        cnt_d = '0;
        if (cur == LANE_WORD0) begin
          w0_d = aligned[SR_W-1 -: WORD_KEEP];
          // interleaved pin: i word first, then q word
          state_d = lp.two_words ? LANE_WORD1 : LANE_IDLE;
          done_d = !lp.two_words;
        end else begin
          w1_d = aligned[SR_W-1 -: WORD_KEEP];
          state_d = LANE_IDLE;
          done_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= LANE_IDLE;
      sr_q <= '0;
      cnt_q <= '0;
      w0_q <= '0;
      w1_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      w0_q <= w0_d;
      w1_q <= w1_d;
      done_q <= done_d;
    end
  end

  assign lp.w0 = w0_q;
  assign lp.w1 = w1_q;
  assign lp.done = done_q;

  chk_done_after_stb: assert property (@(posedge core_clk) disable iff (!rst_b)
    lp.done |-> $past(lp.bit_stb) && $past(lp.word_len) <= $past(new_cnt))
    else $error("word done without a completing bit strobe");
endmodule // serial_word_lane

//--- duc_serial_baseband_input.sv
// serial baseband input for one even/odd upconverter block pair
// assumes pins and sync sources are asynchronous; AHB-Lite single slave
`timescale 1ns/1ps
// How it works
// - dual cdma signals share one output path, a then b, time-shared.
// - mode bit set: two-pin block carries two cdma signals; clear: one umts.
// - cdma: pin a is signal a, pin b signal b; i then q, msb first.
// - words up to 32 bits accepted; only the upper 18 bits kept.
// - umts two-pin: pin a carries i, pin b carries q, msb first.
// - four-pin: even block uses odd pins for q; odd block idle.
// - the pair shares divider, frame timing, sync and frame strobe.
// - bit clock is core clock over one plus divider; sync aligns it.
// - frame interval is 1 to 127 bit periods.
// - word length is field value plus one; 0x11 gives 18 bits.
// - frame strobe leads the expected msb by 0 to 3 bit clocks.
// - a 3-bit select picks the sync source that places the msb.
// - msb captured 3rd edge after sync at full rate, 4th at half.
// - pin-mode bit: 0 two-pin input, 1 four-pin umts input.
module duc_serial_baseband_input import duc_serial_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial pins and sync sources
  input wire logic serial_even_a,
  input wire logic serial_even_b,
  input wire logic serial_odd_a,
  input wire logic serial_odd_b,
  input wire logic [SYNC_SRCS-1:0] sync_src,
  // frame strobe pin
  output logic frame_strobe,
  // word pairs to the gain stage, one entry per block
  output logic [BLOCKS-1:0][WORD_KEEP-1:0] blk_i_word,
  output logic [BLOCKS-1:0][WORD_KEEP-1:0] blk_q_word,
  output logic [BLOCKS-1:0] blk_sig_b,
  output logic [BLOCKS-1:0] blk_valid
);
  // synchronisers
  logic [SYNC_SRCS-1:0] sy1_q, sy2_q, sy3_q;
  logic [LANES-1:0] pin1_q, pin2_q;
  // configuration
  logic [3:0] clkdiv_q, clkdiv_d;
  logic [6:0] fsinv_q, fsinv_d;
  logic [4:0] bits_q, bits_d;
  logic [1:0] fsdel_q, fsdel_d;
  logic [2:0] mode_q, mode_d;
  logic [2:0] ssel_q, ssel_d;
  // bus
  logic wr_q, wr_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [31:0] rd_val;
  logic acc, mapped;
  // timing
  logic [4:0] div_cnt_q, div_cnt_d;
  logic [6:0] pos_q, pos_d;
  logic fstrobe_q, fstrobe_d;
  logic [6:0] fsinv_eff;
  logic [7:0] lead_sum;
  logic bit_stb, frame_start, sync_ev;
  logic four_pin, cdma_even, cdma_odd;
  // lanes and outputs
  logic [LANES-1:0][1:0] l_din;
  logic [LANES-1:0] l_two_words, l_run;
  logic [LANES-1:0][WORD_KEEP-1:0] l_w0, l_w1;
  logic [LANES-1:0] l_done;
  logic [BLOCKS-1:0] blk_cdma, pend_b_q, pend_b_d;
  logic [BLOCKS-1:0][WORD_KEEP-1:0] oi_q, oi_d, oq_q, oq_d;
  logic [BLOCKS-1:0] sigb_q, sigb_d, val_q, val_d;

  // first stage feeds only the second; edge detection reads stage two
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      pin1_q <= '0;
      pin2_q <= '0;
    end else begin
      sy1_q <= sync_src;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin1_q <= {serial_odd_b, serial_odd_a, serial_even_b, serial_even_a};
      pin2_q <= pin1_q;
    end
  end

  assign four_pin = mode_q[MODE_FOUR_PIN];
  assign cdma_even = mode_q[MODE_CDMA_EVEN];
  assign cdma_odd = mode_q[MODE_CDMA_ODD];
  assign sync_ev = sy2_q[ssel_q] & ~sy3_q[ssel_q];
  assign fsinv_eff = (fsinv_q < FSINV_MIN) ? FSINV_MIN : fsinv_q;

  // register bus: zero wait states, read data latched in address phase
  always_comb begin
    acc = hsel && hready && htrans[1];
    mapped = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'h0);
    unique case (haddr[ADDR_W-1:0])
      REG_CLKDIV: rd_val = {28'h0000000, clkdiv_q};
      REG_FRAME: rd_val = {25'h0000000, fsinv_q};
      REG_WORD: rd_val = {27'h0000000, bits_q};
      REG_FSDEL: rd_val = {30'h00000000, fsdel_q};
      REG_MODE: rd_val = {29'h00000000, mode_q};
      REG_SYNC: rd_val = {29'h00000000, ssel_q};
      REG_STATUS: rd_val = {24'h000000, fstrobe_q, pos_q};
      REG_LAST_I: rd_val = {14'h0000, oi_q[0]};
      default: rd_val = 32'h00000000;
    endcase
    if (!mapped) begin
      rd_val = 32'h00000000;
    end
    hrdata_d = (acc && !hwrite) ? rd_val : hrdata_q;
    wr_d = acc && hwrite && mapped;
    waddr_d = acc ? haddr[ADDR_W-1:0] : waddr_q;
    clkdiv_d = clkdiv_q;
    fsinv_d = fsinv_q;
    bits_d = bits_q;
    fsdel_d = fsdel_q;
    mode_d = mode_q;
    ssel_d = ssel_q;
    if (wr_q) begin
      unique case (waddr_q)
        REG_CLKDIV: clkdiv_d = hwdata[3:0];
        REG_FRAME: fsinv_d = hwdata[6:0];
        REG_WORD: bits_d = hwdata[4:0];
        REG_FSDEL: fsdel_d = hwdata[1:0];
        REG_MODE: mode_d = hwdata[2:0];
        REG_SYNC: ssel_d = hwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      waddr_q <= '0;
      hrdata_q <= 32'h00000000;
      clkdiv_q <= RST_CLKDIV;
      fsinv_q <= RST_FSINV;
      bits_q <= RST_BITS;
      fsdel_q <= RST_FSDEL;
      mode_q <= RST_MODE;
      ssel_q <= RST_SSEL;
    end else begin
      wr_q <= wr_d;
      waddr_q <= waddr_d;
      hrdata_q <= hrdata_d;
      clkdiv_q <= clkdiv_d;
      fsinv_q <= fsinv_d;
      bits_q <= bits_d;
      fsdel_q <= fsdel_d;
      mode_q <= mode_d;
      ssel_q <= ssel_d;
    end
  end

  // one divider and frame counter serve both blocks of the pair
  always_comb begin
    bit_stb = (div_cnt_q == 5'h00);
    div_cnt_d = div_cnt_q - 5'h01;
    pos_d = pos_q;
    fstrobe_d = fstrobe_q;
    frame_start = 1'b0;
    lead_sum = 8'h00;
    if (bit_stb) begin
      div_cnt_d = {1'b0, clkdiv_q};
      pos_d = (pos_q >= fsinv_eff - 7'h01) ? 7'h00 : pos_q + 7'h01;
      frame_start = (pos_d == 7'h00);
      lead_sum = {1'b0, pos_d} + {6'h00, fsdel_q};
      fstrobe_d = (lead_sum == {1'b0, fsinv_eff}) ||
                  (fsdel_q == 2'h0 && pos_d == 7'h00);
    end
    // sync realigns the divider so the msb strobe lands at a fixed edge
    if (sync_ev) begin
      div_cnt_d = {1'b0, clkdiv_q} + SYNC_LOAD_ADJ;
      pos_d = fsinv_eff - 7'h01;
      frame_start = 1'b0;
      // a cancelled frame start must not leave a strobe behind
      fstrobe_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 5'h00;
      pos_q <= 7'h00;
      fstrobe_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      pos_q <= pos_d;
      fstrobe_q <= fstrobe_d;
    end
  end

  // lane steering: 0,1 even block; 2,3 odd block, idle in four-pin mode
  always_comb begin
    l_din[0] = four_pin ? {pin2_q[0], pin2_q[1]} : {1'b0, pin2_q[0]};
    l_din[1] = four_pin ? {pin2_q[2], pin2_q[3]} : {1'b0, pin2_q[1]};
    l_din[2] = {1'b0, pin2_q[2]};
    l_din[3] = {1'b0, pin2_q[3]};
    l_two_words = {cdma_odd, cdma_odd, 2'b00};
    if (cdma_even && !four_pin) begin
      l_two_words[1:0] = 2'b11;
    end
    l_run = four_pin ? 4'h3 : 4'hF;
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : gen_lane
      lane_if lif ();
      assign lif.bit_stb = bit_stb && l_run[g];
      assign lif.frame_start = frame_start && l_run[g];
      assign lif.din = l_din[g];
      assign lif.two_bit = four_pin && l_run[g];
      assign lif.two_words = l_two_words[g];
      assign lif.word_len = {1'b0, bits_q} + CNT_W'(1);
      assign l_w0[g] = lif.w0;
      assign l_w1[g] = lif.w1;
      assign l_done[g] = lif.done;
      serial_word_lane u_lane (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .lp(lif.lane)
      );
    end
  endgenerate

  // one output path per block: signal a, then signal b a cycle later
  always_comb begin
    blk_cdma = {cdma_odd, cdma_even && !four_pin};
    pend_b_d = pend_b_q;
    oi_d = oi_q;
    oq_d = oq_q;
    sigb_d = '0;
    val_d = '0;
    for (int b = 0; b < BLOCKS; b++) begin
      if (l_done[2*b]) begin
        val_d[b] = 1'b1;
        oi_d[b] = l_w0[2*b];
        oq_d[b] = blk_cdma[b] ? l_w1[2*b] : l_w0[2*b+1];
        pend_b_d[b] = blk_cdma[b];
      end else if (pend_b_q[b]) begin
        val_d[b] = 1'b1;
        sigb_d[b] = 1'b1;
        oi_d[b] = l_w0[2*b+1];
        oq_d[b] = l_w1[2*b+1];
        pend_b_d[b] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_b_q <= '0;
      oi_q <= '0;
      oq_q <= '0;
      sigb_q <= '0;
      val_q <= '0;
    end else begin
      pend_b_q <= pend_b_d;
      oi_q <= oi_d;
      oq_q <= oq_d;
      sigb_q <= sigb_d;
      val_q <= val_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hrdata = hrdata_q;
  assign hresp = HRESP_OKAY;
  assign frame_strobe = fstrobe_q;
  assign blk_i_word = oi_q;
  assign blk_q_word = oq_q;
  assign blk_sig_b = sigb_q;
  assign blk_valid = val_q;

  chk_msb_full_rate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sync_ev && clkdiv_q == 4'h0) ##1 !sync_ev |=> bit_stb && frame_start)
    else $error("full rate msb strobe not two cycles after sync");
  chk_msb_half_rate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sync_ev && clkdiv_q == 4'h1) ##1 !sync_ev [*2] |=> bit_stb && frame_start)
    else $error("half rate msb strobe not three cycles after sync");
  chk_div_gap: assert property (@(posedge core_clk) disable iff (!rst_b)
    (bit_stb && !sync_ev && clkdiv_q == 4'h1) |=> !bit_stb)
    else $error("bit strobe repeated too soon");
  chk_div_period: assert property (@(posedge core_clk) disable iff (!rst_b)
    (bit_stb && !sync_ev && clkdiv_q == 4'h1) ##1 !sync_ev |=> bit_stb)
    else $error("bit strobe period wrong at half rate");
  chk_frame_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
    (bit_stb && !sync_ev && pos_q == fsinv_eff - 7'h01) |-> frame_start)
    else $error("frame did not restart after interval");
  chk_strobe_zero_lead: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    (frame_start && fsdel_q == 2'h0) |=> frame_strobe)
    else $error("frame strobe missing at msb");
  chk_cdma_share: assert property (@(posedge core_clk) disable iff (!rst_b)
    (l_done[0] && cdma_even && !four_pin) |=>
    (blk_valid[0] && !blk_sig_b[0]) ##1 (blk_valid[0] && blk_sig_b[0]))
    else $error("cdma pair not time-shared a then b");
  chk_umts_single: assert property (@(posedge core_clk) disable iff (!rst_b)
    (l_done[0] && !cdma_even) |=> blk_valid[0] ##1 !blk_valid[0])
    else $error("umts block gave more than one word pair");
  chk_odd_unused: assert property (@(posedge core_clk) disable iff (!rst_b)
    four_pin [*4] |-> !blk_valid[1])
    else $error("odd block active in four-pin mode");
endmodule // duc_serial_baseband_input

//--- serial_source.sv
// behavioural baseband source driving the four serial pins
// assumes frames start at the selected sync rise and repeat each interval
`timescale 1ns/1ps
module serial_source (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // frame setup from the bench
  input wire logic sync,
  input wire logic [3:0] div,
  input wire logic [6:0] fsinv,
  input wire logic [6:0] nbits,
  input wire logic [3:0][63:0] vec,
  // serial pins: even a, even b, odd a, odd b
  output logic [3:0] pins
);
  logic sync_q;
  int e;
  int idx;
  int k;
  int bp;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 1'b0;
      e <= 0;
      pins <= 4'h0;
    end else begin
      sync_q <= sync;
      bp = int'(div) + 1;
      idx = (sync && !sync_q) ? 1 : ((e > 0) ? e + 1 : 0);
      e <= idx;
      // idle line toggles so a stale bit can never pass for data
      if (idx < 1 + bp) begin
        pins <= ~pins;
      end else begin
        k = (idx - 1 - bp) % (int'(fsinv) * bp);
        if (k / bp >= int'(nbits)) begin
          pins <= ~pins;
        end else if (k % bp == 0) begin
          // a new bit only once per bit period, held in between
          for (int p = 0; p < 4; p++) begin
            pins[p] <= vec[p][63 - k / bp];
          end
        end
      end
    end
  end
endmodule // serial_source

//--- tb_top.sv
// self-checking bench for the serial baseband input pair
// assumes a zero-wait ahb-lite slave and the behavioural serial source
`timescale 1ns/1ps
module tb_top;
  import duc_serial_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp, frame_strobe;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, ssel;
  logic [7:0] sync_src;
  logic [3:0] pins, div;
  logic [6:0] fsinv, nbits;
  logic [3:0][63:0] vec;
  logic [BLOCKS-1:0][WORD_KEEP-1:0] blk_i_word, blk_q_word;
  logic [BLOCKS-1:0] blk_sig_b, blk_valid;
  wire logic hready;
  wire logic msync;
  int compares = 0;
  int n_errors = 0;
  int cyc = 0;
  assign hready = hreadyout;
  assign msync = sync_src[ssel];

  duc_serial_baseband_input duc_serial_baseband_input_i (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .serial_even_a(pins[0]), .serial_even_b(pins[1]),
    .serial_odd_a(pins[2]), .serial_odd_b(pins[3]), .sync_src(sync_src),
    .frame_strobe(frame_strobe), .blk_i_word(blk_i_word),
    .blk_q_word(blk_q_word), .blk_sig_b(blk_sig_b), .blk_valid(blk_valid)
  );
  serial_source serial_source_i (
    .core_clk(core_clk), .rst_b(rst_b), .sync(msync), .div(div),
    .fsinv(fsinv), .nbits(nbits), .vec(vec), .pins(pins)
  );

  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(string n, logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(n, q, exp);
  endtask
  // word top-aligned in 64 bits; expected kept part is bits 63..46
  function automatic logic [63:0] top(logic [31:0] w, int l);
    return {w, 32'h00000000} << (32 - l);
  endfunction
  function automatic logic [31:0] keep(logic [31:0] w, int l);
    logic [63:0] t;
    t = top(w, l);
    return {14'h0000, t[63:46]};
  endfunction
  function automatic logic [63:0] half(logic [63:0] t, int s);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < 32; k++) r[63 - k] = t[63 - 2 * k - s];
    return r;
  endfunction
  task automatic cfg(int d, int fi, int l, int m, int s);
    wr(REG_CLKDIV, 32'(d));
    wr(REG_FRAME, 32'(fi));
    wr(REG_WORD, 32'(l - 1));
    wr(REG_MODE, 32'(m));
    wr(REG_SYNC, 32'(s));
    div <= 4'(d);
    fsinv <= 7'(fi);
    ssel <= 3'(s);
  endtask
  task automatic go(int skip);
    @(posedge core_clk);
    sync_src[ssel] <= 1'b1;
    repeat (4) @(posedge core_clk);
    sync_src[ssel] <= 1'b0;
    repeat (skip - 4) @(posedge core_clk);
  endtask
  task automatic wait_valid(int b);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (blk_valid[b] !== 1'b1 && n < 60);
    chk("valid", 32'(blk_valid[b]), 32'h1);
  endtask

  task automatic t_regs();
    chk("strobe at reset", 32'(frame_strobe), 32'h0);
    rdchk("clkdiv", REG_CLKDIV, 32'(RST_CLKDIV));
    rdchk("interval", REG_FRAME, 32'(RST_FSINV));
    rdchk("bits", REG_WORD, 32'(RST_BITS));
    rdchk("lead", REG_FSDEL, 32'(RST_FSDEL));
    rdchk("mode", REG_MODE, 32'(RST_MODE));
    rdchk("sync sel", REG_SYNC, 32'(RST_SSEL));
    wr(REG_CLKDIV, 32'hFFFFFFFF);
    rdchk("clkdiv field", REG_CLKDIV, 32'h0000000F);
    wr(REG_FRAME, 32'hFFFFFFFF);
    rdchk("interval field", REG_FRAME, 32'h0000007F);
    wr(8'h20, 32'h00000005);
    rdchk("unmapped", 8'h20, 32'h00000000);
    chk("hresp", 32'(hresp), 32'(HRESP_OKAY));
    chk("hready", 32'(hreadyout), 32'h1);
  endtask
  task automatic t_umts(int d, int l, logic [31:0] wi, logic [31:0] wq);
    cfg(d, 127, l, 0, 3);
    nbits <= 7'(l);
    vec <= {top(~wq, l), top(~wi, l), top(wq, l), top(wi, l)};
    go(3 + d + (l - 1) * (d + 1));
    wait_valid(0);
    chk("umts sig b", 32'(blk_sig_b[0]), 32'h0);
    chk("umts i", 32'(blk_i_word[0]), keep(wi, l));
    chk("umts q", 32'(blk_q_word[0]), keep(wq, l));
    chk("odd i", 32'(blk_i_word[1]), keep(~wi, l));
    chk("odd q", 32'(blk_q_word[1]), keep(~wq, l));
    rdchk("last i", REG_LAST_I, keep(wi, l));
  endtask
  task automatic t_cdma(int d, int l);
    logic [63:0] sa, sb;
    sa = top(32'h0002A5C3, l) | (top(32'h00015A3C, l) >> l);
    sb = top(32'h0003F00F, l) | (top(32'h0000C3C3, l) >> l);
    // both blocks dual cdma so the odd block's mode bit is exercised too
    cfg(d, 127, l, 6, 5);
    nbits <= 7'(2 * l);
    vec <= {sb, sa, sb, sa};
    go(3 + d + (2 * l - 1) * (d + 1));
    wait_valid(0);
    chk("a sig b", 32'(blk_sig_b[0]), 32'h0);
    chk("a i", 32'(blk_i_word[0]), keep(32'h0002A5C3, l));
    chk("a q", 32'(blk_q_word[0]), keep(32'h00015A3C, l));
    chk("odd a valid", 32'(blk_valid[1]), 32'h1);
    chk("odd a i", 32'(blk_i_word[1]), keep(32'h0002A5C3, l));
    @(posedge core_clk);
    chk("odd b sig b", 32'(blk_sig_b[1]), 32'h1);
    chk("odd b q", 32'(blk_q_word[1]), keep(32'h0000C3C3, l));
    chk("b valid", 32'(blk_valid[0]), 32'h1);
    chk("b sig b", 32'(blk_sig_b[0]), 32'h1);
    chk("b i", 32'(blk_i_word[0]), keep(32'h0003F00F, l));
    chk("b q", 32'(blk_q_word[0]), keep(32'h0000C3C3, l));
  endtask
  task automatic t_four(int d, int l, logic [31:0] wi, logic [31:0] wq);
    cfg(d, 127, l, 1, 7);
    nbits <= 7'((l + 1) / 2);
    vec <= {half(top(wq, l), 1), half(top(wq, l), 0),
            half(top(wi, l), 1), half(top(wi, l), 0)};
    go(3 + d + ((l + 1) / 2 - 1) * (d + 1));
    wait_valid(0);
    chk("four i", 32'(blk_i_word[0]), keep(wi, l));
    chk("four q", 32'(blk_q_word[0]), keep(wq, l));
  endtask
  task automatic rise(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (frame_strobe !== 1'b1);
  endtask
  task automatic t_strobe();
    int t0, t, w, n;
    cfg(1, 20, 18, 0, 0);
    for (int f = 0; f < 4; f++) begin
      wr(REG_FSDEL, 32'(f));
      rise(n);
      go(4);
      rise(t);
      if (f == 0)
        t0 = t;
      else
        chk("lead", 32'(t - t0), 32'((20 - f) * 2));
      w = 0;
      while (frame_strobe === 1'b1) begin
        @(posedge core_clk);
        w++;
      end
      chk("strobe width", 32'(w), 32'h2);
      rise(n);
      chk("strobe period", 32'(w + n), 32'd40);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ceiling well above the thousand or so cycles the scenarios need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    sync_src = 8'h00;
    ssel = 3'h0;
    div = 4'h0;
    fsinv = 7'h7F;
    nbits = 7'h00;
    vec = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_umts(0, 18, 32'h0002B3C5, 32'h0001D00F);
    t_umts(1, 24, 32'h00A5C3F1, 32'h005A3C0E);
    t_umts(2, 12, 32'h00000A5C, 32'h000005A3);
    t_cdma(0, 18);
    t_cdma(1, 16);
    t_four(1, 18, 32'h0003A5C1, 32'h00015A3E);
    t_strobe();
    finish_test();
  end
endmodule // tb_top
